/* shared/msc_pkg.sv */
// Package for the memory scan checker: register map, fields, timing and types
package msc_pkg;

  // Register byte addresses (printed offsets are indices, address = 4 * index)
  localparam logic [7:0] CTRL_IDX     = 8'h00;
  localparam logic [7:0] SETUP_IDX    = 8'h01;
  localparam logic [7:0] FLAGS_IDX    = 8'h02;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h03;
  localparam logic [7:0] IRQ_EN_IDX   = 8'h04;
  localparam logic [7:0] IRQ_CLR_IDX  = 8'h05;
  localparam logic [9:0] CTRL_ADDR     = {CTRL_IDX, 2'b00};
  localparam logic [9:0] SETUP_ADDR    = {SETUP_IDX, 2'b00};
  localparam logic [9:0] FLAGS_ADDR    = {FLAGS_IDX, 2'b00};
  localparam logic [9:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [9:0] IRQ_EN_ADDR   = {IRQ_EN_IDX, 2'b00};
  localparam logic [9:0] IRQ_CLR_ADDR  = {IRQ_CLR_IDX, 2'b00};

  // Control register bits
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ARM_BIT    = 1;
  localparam int CTRL_SRST_BIT   = 7;
  // Setup register fields
  localparam int SEL_LSB  = 0;
  localparam int MODE_LSB = 4;
  // Flags register bits
  localparam int FLAG_BUSY_BIT = 0;
  localparam int FLAG_PASS_BIT = 1;
  // Interrupt status bits: check done, check failed
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;

  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h02;

  localparam logic [1:0] MODE_PRIORITY = 2'h0;
  localparam logic [1:0] SEL_WHOLE     = 2'h0;
  localparam logic [1:0] SEL_LDR_CODE  = 2'h1;
  localparam logic [1:0] SEL_LDR       = 2'h2;

  // Timing
  localparam int START_DELAY_CYC = 3;
  localparam int FETCH_PERIOD    = 3;

  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SCAN  = 2'b10,
    ST_CHECK = 2'b11
  } msc_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } msc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } msc_apb_rsp_s;

endpackage : msc_pkg

/* rtl/msc_checker.sv */
// Memory scan checker: setup and status registers, CRC scan engine, APB slave
//
// Behaviour
// R1 - Setup writes ignored while busy or alarmed
// R2 - Mode field bits 5:4, 0 is priority
// R3 - Startup check leaves mode nonzero; software clears
// R4 - Section field bits 1:0 picks area
// R5 - Startup check leaves checked section readable
// R6 - Status read-only, resets to 0x02
// R7 - Pass flag set by reset, cleared enabling
// R8 - Pass reads zero while checking; one means match
// R9 - Busy bit set while checking; control restricted
// R10 - Continuous runs assumed passing until failure; no continuous mode here: a nonzero mode ends without a scan, pass left clear
// R11 - Mismatch clears pass; armed alarm latches forever
// R12 - One 16-bit fetch every third cycle, CPU stalled
// R13 - Checksum in last two section bytes, high first
// R14 - Check begins three cycles after enable
// R15 - CRC16 CCITT, seed all ones, MSB first
// R16 - Reserved encodings finish at once, pass unchanged
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module msc_checker #(
  parameter int          ADDR_W     = 13,
  parameter logic [15:0] POLY       = msc_pkg::CRC_POLY,
  parameter logic [15:0] SEED       = msc_pkg::CRC_SEED,
  parameter logic [12:0] WHOLE_END  = 13'h1FFF,
  parameter logic [12:0] CODE_END   = 13'h17FF,
  parameter logic [12:0] LDR_END    = 13'h07FF
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire msc_pkg::msc_apb_req_s apbReq,
  output var  msc_pkg::msc_apb_rsp_s apbRsp,
  input  wire logic                 bootScanDone,
  input  wire logic [1:0]           bootScanSel,
  input  wire logic [1:0]           bootScanMode,
  input  wire logic [15:0]          memData,
  output logic [ADDR_W-1:0]         memAddr,
  output logic                      memRead,
  output logic                      cpuStall,
  output logic                      fatalAlarm,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // All state in one record; r_d is rebuilt from r_q every cycle
  typedef struct packed {
    msc_pkg::msc_state_e state;
    logic [7:0]          setup;
    logic                enable;
    logic                arm;
    logic                busy;
    logic                pass;
    logic                alarm;
    logic [1:0]          delay;
    logic [1:0]          phase;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         crc;
    logic [1:0]          irqStat;
    logic [1:0]          irqEn;
    logic                memRead;
    logic                stall;
    logic                irqOut;
    logic                pready;
    logic [31:0]         prdata;
    logic                bootSeen;
  } msc_regs_s;

  msc_regs_s r_q;
  msc_regs_s r_d;

  // Bitwise CRC step over one 16-bit word, most significant bit first
  // Sixteen chained stages in one cycle: this path limits how fast clk_sys may run
  function automatic logic [15:0] crcWord(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] acc;
    acc = c;
    for (int i = 15; i >= 0; i--) begin
      if (acc[15] ^ w[i]) begin
        acc = (acc << 1) ^ POLY;
      end else begin
        acc = acc << 1;
      end
    end
    return acc;
  endfunction : crcWord

  // Reserved section code falls back to the whole array; validCfg keeps it from running
  function automatic logic [ADDR_W-1:0] sectionEnd(input logic [1:0] sel);
    case (sel)
      msc_pkg::SEL_LDR_CODE: sectionEnd = CODE_END[ADDR_W-1:0];
      msc_pkg::SEL_LDR:      sectionEnd = LDR_END[ADDR_W-1:0];
      default:               sectionEnd = WHOLE_END[ADDR_W-1:0];
    endcase
  endfunction : sectionEnd

  ////////////////////////////////////////////////////////////////////////////
  logic        wrEn;
  logic        rdEn;
  logic [9:0]  regAddr;
  logic [7:0]  wByte;
  logic [1:0]  selF;
  logic [1:0]  modeF;
  logic        validCfg;
  logic        fetchSlot;
  logic        consumeSlot;
  logic        lastWord;
  logic        startNow;
  logic        crcOk;
  logic [1:0]  irqSet;

  // Upper address bits are not decoded, so the map repeats every 1 KB
  assign wrEn     = apbReq.psel && apbReq.penable && apbReq.pwrite && !r_q.pready;
  assign rdEn     = apbReq.psel && apbReq.penable && !apbReq.pwrite && !r_q.pready;
  assign regAddr  = apbReq.paddr[9:0];
  assign wByte    = apbReq.pwdata[7:0];
  assign selF     = r_q.setup[msc_pkg::SEL_LSB +: 2];
  assign modeF    = r_q.setup[msc_pkg::MODE_LSB +: 2];
  assign validCfg = (modeF == msc_pkg::MODE_PRIORITY) && (selF != 2'h3); // R2 R4 R16

  assign fetchSlot   = (r_q.phase == 2'h0); // R12
  assign consumeSlot = (r_q.phase == 2'(msc_pkg::FETCH_PERIOD - 1));
  assign lastWord    = (r_q.addr >= sectionEnd(selF) - ADDR_W'(1));
  assign startNow    = (r_q.delay == 2'(msc_pkg::START_DELAY_CYC - 1)); // R14
  assign crcOk       = (r_q.crc == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: startup load, scan engine, then register writes and reads
  always_comb begin
    r_d = r_q;
    r_d.pready = 1'b0;
    r_d.prdata = 32'h0000_0000;
    irqSet     = 2'b00;

    // Startup check result loads once into setup; mode stays nonzero until software rewrites it
    // The arm bit is left clear: only software may set it
    if (bootScanDone && !r_q.bootSeen) begin
      r_d.bootSeen = 1'b1;
      r_d.setup    = 8'h00;
      r_d.setup[msc_pkg::MODE_LSB +: 2] = (bootScanMode == 2'h0) ? 2'h1 : bootScanMode; // R3
      r_d.setup[msc_pkg::SEL_LSB +: 2]  = bootScanSel; // R5
      r_d.enable   = 1'b1;
    end

    // Scan engine
    case (r_q.state)
      msc_pkg::ST_IDLE: begin
        // CPU owns the memory; no fetches
        r_d.stall   = 1'b0;
        r_d.memRead = 1'b0;
      end
      msc_pkg::ST_DELAY: begin
        // CPU keeps running during the start delay
        if (startNow) begin // R14
          if (validCfg) begin
            r_d.state = msc_pkg::ST_SCAN;
            r_d.stall = 1'b1; // R12
            r_d.addr  = '0;
            r_d.crc   = SEED; // R15
            r_d.phase = 2'h0;
          end else begin
            // Nothing is fetched, so the pass flag keeps the value the enable left
            r_d.state = msc_pkg::ST_IDLE; // R16
            r_d.busy  = 1'b0;
            irqSet[msc_pkg::IRQ_DONE_BIT] = 1'b1;
          end
        end else begin
          r_d.delay = r_q.delay + 2'h1;
        end
      end
      msc_pkg::ST_SCAN: begin
        // Fetch in slot 0, the word lands two cycles later and is consumed in the last slot
        r_d.memRead = fetchSlot; // R12
        if (consumeSlot) begin
          r_d.phase = 2'h0;
          // Checksum words sit at the section end and run through the CRC too; residue zero is a match
          r_d.crc   = crcWord(r_q.crc, memData); // R13 R15
          if (lastWord) begin
            r_d.state = msc_pkg::ST_CHECK;
          end else begin
            r_d.addr = r_q.addr + ADDR_W'(2);
          end
        end else begin
          r_d.phase = r_q.phase + 2'h1;
        end
      end
      msc_pkg::ST_CHECK: begin
        r_d.state   = msc_pkg::ST_IDLE;
        r_d.busy    = 1'b0; // R9
        r_d.stall   = 1'b0;
        r_d.memRead = 1'b0;
        irqSet[msc_pkg::IRQ_DONE_BIT] = 1'b1;
        if (crcOk) begin
          r_d.pass = 1'b1; // R8
        end else begin
          r_d.pass = 1'b0; // R11
          irqSet[msc_pkg::IRQ_FAIL_BIT] = 1'b1;
          if (r_q.arm) begin
            r_d.alarm = 1'b1; // R11
          end
        end
      end
      default: begin
        // An unused state code drops back to idle and frees the CPU
        r_d.state   = msc_pkg::ST_IDLE;
        r_d.busy    = 1'b0;
        r_d.stall   = 1'b0;
        r_d.memRead = 1'b0;
      end
    endcase

    // APB writes; control and setup not writable once the alarm fired
    if (wrEn) begin
      r_d.pready = 1'b1;
      case (regAddr)
        msc_pkg::CTRL_ADDR: begin
          if (!r_q.alarm) begin
            // With arm set a running check cannot be abandoned by a soft reset
            if (wByte[msc_pkg::CTRL_SRST_BIT] && !(r_q.arm && r_q.busy)) begin
              r_d.state   = msc_pkg::ST_IDLE;
              r_d.setup   = msc_pkg::SETUP_RESET;
              r_d.enable  = 1'b0;
              r_d.busy    = 1'b0;
              r_d.pass    = 1'b0;
              r_d.stall   = 1'b0;
              r_d.memRead = 1'b0;
            end else begin
              if (wByte[msc_pkg::CTRL_ARM_BIT] && !r_q.busy) begin
                r_d.arm = 1'b1; // R9
              end
              // Enable written during a check is recorded but does not restart it
              r_d.enable = wByte[msc_pkg::CTRL_ENABLE_BIT];
              if (wByte[msc_pkg::CTRL_ENABLE_BIT] && !r_q.busy) begin
                r_d.pass  = 1'b0; // R7
                r_d.busy  = 1'b1; // R9
                r_d.delay = 2'h0;
                r_d.state = msc_pkg::ST_DELAY; // R14
              end
            end
          end
        end
        msc_pkg::SETUP_ADDR: begin
          if (!r_q.busy && !r_q.alarm) begin // R1
            r_d.setup = wByte & 8'h33;
          end
        end
        msc_pkg::IRQ_EN_ADDR: begin
          r_d.irqEn = wByte[1:0];
        end
        msc_pkg::IRQ_CLR_ADDR: begin
          // Write one to clear; an event in the same cycle is merged back below
          r_d.irqStat = r_q.irqStat & ~wByte[1:0];
        end
        // Flags and status are read-only
        default: ; // R6
      endcase
    end

    // Reads answer one cycle after the take, like writes
    if (rdEn) begin
      r_d.pready = 1'b1;
      case (regAddr)
        msc_pkg::CTRL_ADDR:     r_d.prdata = {30'h0, r_q.arm, r_q.enable};
        msc_pkg::SETUP_ADDR:    r_d.prdata = {24'h0, r_q.setup};
        // Pass is masked by busy so a stale result never shows mid-check
        msc_pkg::FLAGS_ADDR:    r_d.prdata = {30'h0, r_q.pass & ~r_q.busy, r_q.busy}; // R8 R9
        msc_pkg::IRQ_STAT_ADDR: r_d.prdata = {30'h0, r_q.irqStat};
        msc_pkg::IRQ_EN_ADDR:   r_d.prdata = {30'h0, r_q.irqEn};
        default:                r_d.prdata = 32'h0000_0000;
      endcase
    end

    // Set wins over a clear written in the same cycle
    r_d.irqStat = r_d.irqStat | irqSet;
    r_d.irqOut  = |(r_d.irqStat & r_d.irqEn);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pass starts set: a status read straight after reset shows a good result
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q          <= '0;
      r_q.state    <= msc_pkg::ST_IDLE;
      r_q.setup    <= msc_pkg::SETUP_RESET;
      r_q.pass     <= msc_pkg::FLAGS_RESET[msc_pkg::FLAG_PASS_BIT]; // R6 R7
      r_q.busy     <= msc_pkg::FLAGS_RESET[msc_pkg::FLAG_BUSY_BIT];
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output except pslverr (tied low) is a register field, with no logic after the flip-flop
  assign apbRsp.pready  = r_q.pready;
  assign apbRsp.pslverr = 1'b0;
  assign apbRsp.prdata  = r_q.prdata;
  assign memAddr        = r_q.addr;
  assign memRead        = r_q.memRead;
  assign cpuStall       = r_q.stall;
  assign fatalAlarm     = r_q.alarm;
  assign irq            = r_q.irqOut;

endmodule : msc_checker
`default_nettype wire

/* tb/msc_checker_assertions.sv */
// Port-level checks on the memory scan checker
`timescale 1ns/100ps
`default_nettype none
module msc_checker_assertions #(
  parameter int ADDR_W = 13
) (
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire msc_pkg::msc_apb_req_s apbReq,
  input wire msc_pkg::msc_apb_rsp_s apbRsp,
  input wire logic                  bootScanDone,
  input wire logic [1:0]            bootScanSel,
  input wire logic [1:0]            bootScanMode,
  input wire logic [15:0]           memData,
  input wire logic [ADDR_W-1:0]     memAddr,
  input wire logic                  memRead,
  input wire logic                  cpuStall,
  input wire logic                  fatalAlarm,
  input wire logic                  irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  ready_after_take_a: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
    else $error("no ready one cycle after take");
  ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready longer than one cycle");
  no_slave_err_a: assert property (!apbRsp.pslverr)
    else $error("slave error raised");
  fetch_spacing_a: assert property (memRead |=> !memRead ##1 !memRead)
    else $error("fetches closer than three cycles");
  fetch_stalled_a: assert property (memRead |-> cpuStall)
    else $error("fetch without stall");
  even_fetch_a: assert property (memRead |-> !memAddr[0])
    else $error("odd word address");
  alarm_sticky_a: assert property (fatalAlarm |=> fatalAlarm)
    else $error("alarm dropped before reset");
  alarm_after_scan_a: assert property ($rose(fatalAlarm) |-> !cpuStall)
    else $error("alarm during scan");
  // CPU keeps running during the start delay
  start_delay_a: assert property (apbReq.psel && apbReq.penable && apbReq.pwrite && !apbRsp.pready
    && apbReq.paddr == 12'(msc_pkg::CTRL_ADDR) && apbReq.pwdata[0] && !cpuStall |=> !cpuStall[*3])
    else $error("stall inside start delay");
  fetch_period_a: assert property (memRead |-> ##3 (memRead || !cpuStall))
    else $error("fetch slot not every third cycle");
  first_fetch_a: assert property ($rose(cpuStall) |=> memRead)
    else $error("no fetch right after stall");
endmodule : msc_checker_assertions
`default_nettype wire

/* tb/msc_mem_model.sv */
// Behavioural program memory answering the scan fetches
`timescale 1ns/100ps
`default_nettype none
module msc_mem_model #(
  parameter int ADDR_W = 13
) (
  input  wire logic              clk_sys,
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic              memRead,
  output logic [15:0]            memData
);
  logic [15:0] words [0:7];
  logic        held_q;
  // Word holds two cycles, then flips so a late sample cannot match by luck
  always_ff @(posedge clk_sys) begin
    held_q <= memRead;
    if (memRead) memData <= words[memAddr[3:1]];
    else if (!held_q) memData <= ~memData;
  end
endmodule : msc_mem_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the memory scan checker
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int ADDR_W = 13;
  localparam logic [9:0] SU = msc_pkg::SETUP_ADDR;
  localparam logic [9:0] FL = msc_pkg::FLAGS_ADDR;
  localparam logic [9:0] IS = msc_pkg::IRQ_STAT_ADDR;
  localparam logic [9:0] IC = msc_pkg::IRQ_CLR_ADDR;
  localparam logic [9:0] IE = msc_pkg::IRQ_EN_ADDR;
  localparam logic [9:0] CT = msc_pkg::CTRL_ADDR;
  logic                  clk_sys = 1'b0;
  logic                  srst = 1'b1;
  msc_pkg::msc_apb_req_s apbReq = '0;
  msc_pkg::msc_apb_rsp_s apbRsp;
  logic                  bootScanDone = 1'b1;
  logic [15:0]           memData;
  logic [ADDR_W-1:0]     memAddr;
  logic                  memRead, cpuStall, fatalAlarm, irq;
  logic                  chkRd = 1'b0;
  logic [7:0]            notes[$];
  int                    miscompares = 0;
  int                    checked = 0;
  always #50 clk_sys = ~clk_sys;
  // Small section ends keep every scan short
  msc_checker #(.WHOLE_END(13'h000F), .CODE_END(13'h000B), .LDR_END(13'h0007)) uut (.clk_sys(clk_sys),
    .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .bootScanDone(bootScanDone), .bootScanSel(2'h1),
    .bootScanMode(2'h0), .memData(memData), .memAddr(memAddr), .memRead(memRead), .cpuStall(cpuStall),
    .fatalAlarm(fatalAlarm), .irq(irq));
  msc_mem_model #(.ADDR_W(ADDR_W)) flash (.clk_sys(clk_sys), .memAddr(memAddr), .memRead(memRead),
    .memData(memData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic c,
                      output logic [7:0] r);
    int n;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, a}, pwdata: {24'h00_0000, d}};
    chkRd <= c;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    r = apbRsp.prdata[7:0];
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    chkRd <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, 1'b0, r);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] r;
    notes.push_back(e);
    xfer(1'b0, a, 8'h00, 1'b1, r);
  endtask : rd
  // Read results are judged here, oldest note first
  always @(posedge clk_sys) begin
    if (apbRsp.pready === 1'b1 && chkRd === 1'b1) cmp(apbRsp.prdata[7:0], notes.pop_front());
  end
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) c = (c << 1) ^ ((c[15] ^ w[i]) ? msc_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16
  task automatic run(input logic [7:0] s, input int n, input logic bad, input logic [7:0] c,
                     input logic [7:0] f, input logic [7:0] st, input logic ie);
    logic [15:0] crc;
    logic [7:0]  r;
    int          k;
    crc = msc_pkg::CRC_SEED;
    for (int i = 0; i < n - 1; i++) begin
      flash.words[i] = 16'($urandom);
      crc = crc16(crc, flash.words[i]);
    end
    flash.words[n-1] = crc ^ {15'h0000, bad};
    wr(SU, s);
    wr(CT, c);
    if (n > 1) begin
      rd(FL, 8'h01);
      wr(SU, 8'h12);
    end
    k = 0;
    do begin
      xfer(1'b0, FL, 8'h00, 1'b0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 60);
    if (k >= 60) begin
      miscompares++;
      end_sim();
    end
    rd(SU, s);
    rd(FL, f);
    rd(IS, st);
    cmp({7'h00, irq}, {7'h00, ie});
    wr(IC, 8'h03);
    rd(IS, 8'h00);
    cmp({7'h00, irq}, 8'h00);
  endtask : run
  initial begin
    void'($urandom(2));
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(SU, 8'h11);
    bootScanDone <= 1'b0;
    wr(SU, 8'h00);
    rd(SU, 8'h00);
    rd(FL, 8'h02);
    wr(FL, 8'h01);
    rd(FL, 8'h02);
    rd(10'h03C, 8'h00);
    wr(IE, 8'h03);
    run(8'h00, 8, 1'b0, 8'h01, 8'h02, 8'h01, 1'b1);
    run(8'h01, 6, 1'b0, 8'h01, 8'h02, 8'h01, 1'b1);
    run(8'h30, 1, 1'b0, 8'h01, 8'h00, 8'h01, 1'b1);
    run(8'h03, 1, 1'b0, 8'h01, 8'h00, 8'h01, 1'b1);
    run(8'h02, 4, 1'b1, 8'h01, 8'h00, 8'h03, 1'b1);
    wr(IE, 8'h02);
    run(8'h02, 4, 1'b0, 8'h01, 8'h02, 8'h01, 1'b0);
    wr(CT, 8'h80);
    rd(CT, 8'h00);
    rd(SU, 8'h00);
    rd(FL, 8'h00);
    run(8'h02, 4, 1'b1, 8'h03, 8'h00, 8'h03, 1'b1);
    cmp({7'h00, fatalAlarm}, 8'h01);
    wr(SU, 8'h01);
    rd(SU, 8'h02);
    wr(CT, 8'h80);
    rd(CT, 8'h03);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    cmp({7'h00, fatalAlarm}, 8'h00);
    rd(FL, 8'h02);
    rd(SU, 8'h00);
    end_sim();
  end
endmodule : testbench
bind msc_checker msc_checker_assertions #(.ADDR_W(ADDR_W)) chk (.clk_sys(clk_sys), .srst(srst),
  .apbReq(apbReq), .apbRsp(apbRsp), .bootScanDone(bootScanDone), .bootScanSel(bootScanSel),
  .bootScanMode(bootScanMode), .memData(memData), .memAddr(memAddr), .memRead(memRead),
  .cpuStall(cpuStall), .fatalAlarm(fatalAlarm), .irq(irq));
`default_nettype wire
